//--- pkg/rtcx_pkg.sv
`default_nettype none
package rtcx_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned REG_W  = 24;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_TIME   = 6'h14;
  localparam logic [5:0] IDX_TALARM = 6'h15;
  localparam logic [5:0] IDX_DAY    = 6'h16;
  localparam logic [5:0] IDX_DALARM = 6'h17;
  localparam logic [5:0] IDX_STATUS = 6'h30;
  localparam logic [5:0] IDX_MASK   = 6'h31;

  // Field layout
  localparam int unsigned TOD_LSB   = 0;
  localparam int unsigned TOD_W     = 17;
  localparam int unsigned TRIM_LSB  = 17;
  localparam int unsigned TRIM_W    = 5;
  localparam int unsigned MODE_LSB  = 22;
  localparam int unsigned MODE_W    = 2;
  localparam int unsigned SPARE_LSB = 17;
  localparam int unsigned SPARE_W   = 6;
  localparam int unsigned HALT_BIT  = 23;
  localparam int unsigned DAY_W     = 15;
  localparam int unsigned EVT_W     = 2;
  localparam int unsigned EVT_ALARM = 0;
  localparam int unsigned EVT_DAY   = 1;

  // Reset values
  localparam logic [TOD_W-1:0]   TOD_RST    = 17'h00000;
  localparam logic [TOD_W-1:0]   TALARM_RST = 17'h1FFFF;
  localparam logic [TRIM_W-1:0]  TRIM_RST   = 5'h00;
  localparam logic [MODE_W-1:0]  MODE_RST   = 2'h0;
  localparam logic [SPARE_W-1:0] SPARE_RST  = 6'h00;
  localparam logic               HALT_RST   = 1'b0;
  localparam logic [DAY_W-1:0]   DAY_RST    = 15'h0000;
  localparam logic [DAY_W-1:0]   DALARM_RST = 15'h7FFF;
  localparam logic [EVT_W-1:0]   EVT_RST    = 2'h0;

  // Trim modes
  localparam logic [MODE_W-1:0] TRIM_OFF   = 2'h0;
  localparam logic [MODE_W-1:0] TRIM_SLOW  = 2'h1;
  localparam logic [MODE_W-1:0] TRIM_FAST  = 2'h2;

  // Timing
  localparam int unsigned CLK_HZ      = 100000000;
  localparam int unsigned SEC_TIME_S  = 1;
  localparam int unsigned SEC_CYCLES  = CLK_HZ * SEC_TIME_S;
  localparam int unsigned SEC_PER_DAY = 86400;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- hw/rtcx_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
module rtcx_tick_gen #(
  parameter int unsigned TICK_CYCLES = rtcx_pkg::SEC_CYCLES
) (
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  input  wire logic                              run,
  input  wire logic [rtcx_pkg::MODE_W-1:0]       trim_mode_sel,
  input  wire logic [rtcx_pkg::TRIM_W-1:0]       timekeeper_trim_count,
  output logic                                   tick
);
  logic [31:0] cnt_r;
  logic [31:0] period;

  // Trim stretches or shortens each second by the trim count in cycles
  always_comb
  begin
    case (trim_mode_sel)
      rtcx_pkg::TRIM_SLOW: period = TICK_CYCLES + {27'h0000000, timekeeper_trim_count};
      rtcx_pkg::TRIM_FAST: period = TICK_CYCLES - {27'h0000000, timekeeper_trim_count};
      default:             period = TICK_CYCLES;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cnt_r <= 32'h00000000;
    else if (!run)
      cnt_r <= 32'h00000000;
    else if (cnt_r + 32'h00000001 >= period)
      cnt_r <= 32'h00000000;
    else
      cnt_r <= cnt_r + 32'h00000001;
  end

  assign tick = run && (cnt_r + 32'h00000001 >= period);
endmodule
`default_nettype wire

//--- hw/rtcx_top.sv
`timescale 1ns/100ps
`default_nettype none
module rtcx_top #(
  parameter int unsigned TICK_CYCLES = rtcx_pkg::SEC_CYCLES,
  parameter int unsigned SEC_PER_DAY = rtcx_pkg::SEC_PER_DAY
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [rtcx_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [rtcx_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic [1:0]                         s_axi_bresp,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [rtcx_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [rtcx_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               irq
);
  localparam int unsigned TOD_W  = rtcx_pkg::TOD_W;
  localparam int unsigned DAY_W  = rtcx_pkg::DAY_W;
  localparam int unsigned EVT_W  = rtcx_pkg::EVT_W;
  localparam logic [TOD_W-1:0] TOD_LAST = TOD_W'(SEC_PER_DAY - 1);

  // Register state
  logic [TOD_W-1:0]             seconds_of_date_count_r;
  logic [rtcx_pkg::TRIM_W-1:0]  timekeeper_trim_count_r;
  logic [rtcx_pkg::MODE_W-1:0]  trim_mode_sel_r;
  logic [TOD_W-1:0]             alarm_seconds_value_r;
  logic [rtcx_pkg::SPARE_W-1:0] alarm_spare_r;
  logic                         timekeeper_halt_r;
  logic [DAY_W-1:0]             day_count_r;
  logic [DAY_W-1:0]             alarm_date_value_r;
  logic [EVT_W-1:0]             evt_status_r;
  logic [EVT_W-1:0]             evt_mask_r;

  // Bus state
  logic                         aw_held_r;
  logic                         w_held_r;
  logic [5:0]                   wr_idx_r;
  logic [rtcx_pkg::DATA_W-1:0]  wr_data_r;
  logic [3:0]                   wr_strb_r;
  logic                         match_prev_r;

  logic                         wr_fire;
  logic                         wr_hit;
  logic [rtcx_pkg::DATA_W-1:0]  wr_mask;
  logic [rtcx_pkg::DATA_W-1:0]  wr_val;
  logic                         tick;
  logic                         run;
  logic                         day_wrap;
  logic                         match_now;
  logic [EVT_W-1:0]             evt_set;
  logic [rtcx_pkg::DATA_W-1:0]  rd_word;
  logic                         rd_hit;
  logic [5:0]                   rd_idx;
  logic [rtcx_pkg::DATA_W-1:0]  s_axi_rdata_nxt;
  logic [EVT_W-1:0]             evt_pending;
  logic                         time_wr_en;
  logic                         talarm_wr_en;
  logic                         day_wr_en;
  logic                         dalarm_wr_en;
  logic                         status_wr_en;
  logic                         mask_wr_en;
  logic [rtcx_pkg::DATA_W-1:0]  time_word;
  logic [rtcx_pkg::DATA_W-1:0]  talarm_word;
  logic [rtcx_pkg::DATA_W-1:0]  day_word;
  logic [rtcx_pkg::DATA_W-1:0]  dalarm_word;
  logic [rtcx_pkg::DATA_W-1:0]  status_word;
  logic [rtcx_pkg::DATA_W-1:0]  mask_word;

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held_r <= 1'b0;
      wr_idx_r  <= 6'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      wr_idx_r  <= s_axi_awaddr[7:2];
    end
    else if (wr_fire)
      aw_held_r <= 1'b0;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      w_held_r  <= 1'b0;
      wr_data_r <= 32'h00000000;
      wr_strb_r <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r  <= 1'b1;
      wr_data_r <= s_axi_wdata;
      wr_strb_r <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held_r <= 1'b0;
  end

  always_comb
  begin
    case (wr_idx_r)
      rtcx_pkg::IDX_TIME, rtcx_pkg::IDX_TALARM, rtcx_pkg::IDX_DAY,
      rtcx_pkg::IDX_DALARM, rtcx_pkg::IDX_STATUS, rtcx_pkg::IDX_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= rtcx_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? rtcx_pkg::RESP_OKAY : rtcx_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // One packing per register, shared by read mux and write merge (status by the read mux only) so they cannot drift
  assign time_word   = {8'h00, trim_mode_sel_r, timekeeper_trim_count_r, seconds_of_date_count_r};
  assign talarm_word = {8'h00, timekeeper_halt_r, alarm_spare_r, alarm_seconds_value_r};
  assign day_word    = {17'h00000, day_count_r};
  assign dalarm_word = {17'h00000, alarm_date_value_r};
  assign status_word = {30'h00000000, evt_status_r};
  assign mask_word   = {30'h00000000, evt_mask_r};

  // Byte strobes merged into the stored word
  assign wr_mask = {{8{wr_strb_r[3]}}, {8{wr_strb_r[2]}}, {8{wr_strb_r[1]}}, {8{wr_strb_r[0]}}};

  always_comb
  begin
    case (wr_idx_r)
      rtcx_pkg::IDX_TIME:   rd_word = time_word;
      rtcx_pkg::IDX_TALARM: rd_word = talarm_word;
      rtcx_pkg::IDX_DAY:    rd_word = day_word;
      rtcx_pkg::IDX_DALARM: rd_word = dalarm_word;
      rtcx_pkg::IDX_MASK:   rd_word = mask_word;
      default:              rd_word = 32'h00000000;
    endcase
  end

  assign wr_val = (rd_word & ~wr_mask) | (wr_data_r & wr_mask);

  // One strobe per register so every update sees the same decode
  assign time_wr_en   = wr_fire && (wr_idx_r == rtcx_pkg::IDX_TIME);
  assign talarm_wr_en = wr_fire && (wr_idx_r == rtcx_pkg::IDX_TALARM);
  assign day_wr_en    = wr_fire && (wr_idx_r == rtcx_pkg::IDX_DAY);
  assign dalarm_wr_en = wr_fire && (wr_idx_r == rtcx_pkg::IDX_DALARM);
  assign status_wr_en = wr_fire && (wr_idx_r == rtcx_pkg::IDX_STATUS);
  assign mask_wr_en   = wr_fire && (wr_idx_r == rtcx_pkg::IDX_MASK);

  // Seconds tick; stops while halted
  assign run = !timekeeper_halt_r;

  rtcx_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .sys_clk               (sys_clk),
    .rst                   (rst),
    .run                   (run),
    .trim_mode_sel         (trim_mode_sel_r),
    .timekeeper_trim_count (timekeeper_trim_count_r),
    .tick                  (tick)
  );

  assign day_wrap = tick && (seconds_of_date_count_r >= TOD_LAST);

  // Time register: software write wins over a same-cycle tick
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      seconds_of_date_count_r <= rtcx_pkg::TOD_RST;
    else if (time_wr_en)
      seconds_of_date_count_r <= wr_val[rtcx_pkg::TOD_LSB +: TOD_W];
    else if (day_wrap)
      seconds_of_date_count_r <= rtcx_pkg::TOD_RST;
    else if (tick)
      seconds_of_date_count_r <= seconds_of_date_count_r + 17'h00001;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      timekeeper_trim_count_r <= rtcx_pkg::TRIM_RST;
      trim_mode_sel_r         <= rtcx_pkg::MODE_RST;
    end
    else if (time_wr_en)
    begin
      timekeeper_trim_count_r <= wr_val[rtcx_pkg::TRIM_LSB +: rtcx_pkg::TRIM_W];
      trim_mode_sel_r         <= wr_val[rtcx_pkg::MODE_LSB +: rtcx_pkg::MODE_W];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      alarm_seconds_value_r <= rtcx_pkg::TALARM_RST;
      alarm_spare_r         <= rtcx_pkg::SPARE_RST;
      timekeeper_halt_r     <= rtcx_pkg::HALT_RST;
    end
    else if (talarm_wr_en)
    begin
      alarm_seconds_value_r <= wr_val[rtcx_pkg::TOD_LSB +: TOD_W];
      alarm_spare_r         <= wr_val[rtcx_pkg::SPARE_LSB +: rtcx_pkg::SPARE_W];
      timekeeper_halt_r     <= wr_val[rtcx_pkg::HALT_BIT];
    end
  end

  // Day counter; upper bits are not stored at all
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      day_count_r <= rtcx_pkg::DAY_RST;
    else if (day_wr_en)
      day_count_r <= wr_val[DAY_W-1:0];
    else if (day_wrap)
      day_count_r <= day_count_r + 15'h0001;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      alarm_date_value_r <= rtcx_pkg::DALARM_RST;
    else if (dalarm_wr_en)
      alarm_date_value_r <= wr_val[DAY_W-1:0];
  end

  // Alarm fires once on entering the match, not every cycle it lasts
  assign match_now = run && (seconds_of_date_count_r == alarm_seconds_value_r)
                     && (day_count_r == alarm_date_value_r);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      match_prev_r <= 1'b0;
    else
      match_prev_r <= match_now;
  end

  assign evt_set[rtcx_pkg::EVT_ALARM] = match_now && !match_prev_r;
  assign evt_set[rtcx_pkg::EVT_DAY]   = day_wrap;

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      evt_status_r <= rtcx_pkg::EVT_RST;
    else if (status_wr_en && wr_strb_r[0])
      evt_status_r <= (evt_status_r & ~wr_data_r[EVT_W-1:0]) | evt_set;
    else
      evt_status_r <= evt_status_r | evt_set;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      evt_mask_r <= rtcx_pkg::EVT_RST;
    else if (mask_wr_en)
      evt_mask_r <= wr_val[EVT_W-1:0];
  end

  assign evt_pending = (evt_status_r | evt_set) & evt_mask_r;

  // Registered so the pin never glitches on decode hazards
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |evt_pending;
  end

  // Read channel: one read in flight, data registered at the handshake
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx        = s_axi_araddr[7:2];

  always_comb
  begin
    rd_hit = 1'b1;
    case (rd_idx)
      rtcx_pkg::IDX_TIME:   s_axi_rdata_nxt = time_word;
      rtcx_pkg::IDX_TALARM: s_axi_rdata_nxt = talarm_word;
      rtcx_pkg::IDX_DAY:    s_axi_rdata_nxt = day_word;
      rtcx_pkg::IDX_DALARM: s_axi_rdata_nxt = dalarm_word;
      rtcx_pkg::IDX_STATUS: s_axi_rdata_nxt = status_word;
      rtcx_pkg::IDX_MASK:   s_axi_rdata_nxt = mask_word;
      default:
      begin
        s_axi_rdata_nxt = 32'h00000000;
        rd_hit          = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= rtcx_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= s_axi_rdata_nxt;
      s_axi_rresp  <= rd_hit ? rtcx_pkg::RESP_OKAY : rtcx_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

//--- test/rtcx_checker.sv
`timescale 1ns/100ps
`default_nettype none
module rtcx_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic ar_hs;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  a_day_top_zero: assert property (ar_hs && s_axi_araddr == 8'h58 |=> s_axi_rdata[31:15] == 17'h00000)
    else $error("day register upper bits not zero");
  a_dalarm_top_zero: assert property (ar_hs && s_axi_araddr == 8'h5C |=> s_axi_rdata[31:15] == 17'h00000)
    else $error("day alarm upper bits not zero");
  a_time_lane_ok: assert property (ar_hs && s_axi_araddr == 8'h50 |=> s_axi_rdata[31:24] == 8'h00 && s_axi_rresp == 2'h0)
    else $error("time register read malformed");
  a_alarm_lane_ok: assert property (ar_hs && s_axi_araddr == 8'h54 |=> s_axi_rdata[31:24] == 8'h00 && s_axi_rresp == 2'h0)
    else $error("alarm register read malformed");
  a_unmapped_read: assert property (ar_hs && s_axi_araddr == 8'h00 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  a_read_answer: assert property (ar_hs |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_no_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while read pending");
  a_read_retires: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer kept after it was taken");
endmodule
bind rtcx_top rtcx_checker u_chk (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp);
`default_nettype wire

//--- test/rtcx_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module rtcx_host_model (
  input  wire logic        sys_clk,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic [7:0]       s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  output logic             s_axi_rready
);
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 52'h0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge sys_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_bready  <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge sys_clk);
      ad = ad || s_axi_awready;
      wd = wd || s_axi_wready;
      if (ad)
        s_axi_awvalid <= 1'b0;
      // Released data lines flip so stale values never pass for live ones
      if (wd)
      begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    end
    while (s_axi_bvalid !== 1'b1)
      @(posedge sys_clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- test/rtcx_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rtcx_top_bench;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          failures  = 0;
  int          tests_run = 0;
  // Alarm first: its halt bit freezes the counters for the all-ones pass
  logic [7:0]  regs  [4] = '{8'h54, 8'h50, 8'h58, 8'h5C};
  logic [31:0] rst_v [4] = '{32'h0001FFFF, 32'h0, 32'h0, 32'h00007FFF};
  logic [31:0] ones_v[4] = '{32'h00FFFFFF, 32'h00FFFFFF, 32'h00007FFF, 32'h00007FFF};
  logic [31:0] d;
  logic [1:0]  r;

  always #5 sys_clk = ~sys_clk;

  // Short tick and day so alarms and rollover happen within a few hundred cycles
  rtcx_top #(.TICK_CYCLES(20), .SEC_PER_DAY(10)) u_dut (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq);
  rtcx_host_model u_host (.sys_clk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rr;
    u_host.wr(a, v, rr);
    check({30'h0, rr}, 32'h0);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] dd;
    logic [1:0]  rr;
    u_host.rd(a, dd, rr);
    check(dd, e);
    check({30'h0, rr}, 32'h0);
  endtask

  task automatic irq_is(input logic v);
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq}, {31'h0, v});
  endtask

  // Halt clears the divider, so the seconds seen after a fixed wait depend only on the trim
  task automatic trim_chk(input logic [31:0] tv, input logic [31:0] e);
    wr_ok(8'h54, 32'h00800003);
    wr_ok(8'h50, tv);
    wr_ok(8'h54, 32'h00000003);
    repeat (60) @(posedge sys_clk);
    rd_chk(8'h50, e);
  endtask

  task automatic reset_chk;
    rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (regs[i])
      rd_chk(regs[i], rst_v[i]);
  endtask

  initial
  begin
    reset_chk();
    foreach (regs[i])
      wr_ok(regs[i], 32'hFFFFFFFF);
    foreach (regs[i])
      rd_chk(regs[i], ones_v[i]);
    repeat (100) @(posedge sys_clk);
    rd_chk(8'h50, 32'h00FFFFFF);
    u_host.rd(8'h00, d, r);
    check(d, 32'h0);
    check({30'h0, r}, {30'h0, rtcx_pkg::RESP_SLVERR});
    u_host.wr(8'h00, 32'h1, r);
    check({30'h0, r}, {30'h0, rtcx_pkg::RESP_SLVERR});
    reset_chk();
    wr_ok(8'h50, 32'h0);
    wr_ok(8'h5C, 32'h0);
    wr_ok(8'h54, 32'h3);
    wr_ok(8'hC4, 32'h1);
    for (int i = 0; i < 500 && irq !== 1'b1; i++)
      @(posedge sys_clk);
    check({31'h0, irq}, 32'h1);
    rd_chk(8'hC0, 32'h1);
    wr_ok(8'hC4, 32'h0);
    irq_is(1'b0);
    wr_ok(8'hC4, 32'h1);
    irq_is(1'b1);
    wr_ok(8'hC0, 32'h1);
    irq_is(1'b0);
    rd_chk(8'hC0, 32'h0);
    repeat (150) @(posedge sys_clk);
    rd_chk(8'h58, 32'h1);
    // Trim 5 on a 20-cycle second: 25 cycles slow, 15 fast, 62 cycles elapsed
    trim_chk(32'h004A0000, 32'h004A0002);
    trim_chk(32'h008A0000, 32'h008A0004);
    summarize();
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
